//--- design/smcp_pkg.sv
// constants, register map and reset values of the sync manager cycle parameter bank
package smcp_pkg;

	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [7:0] ADDR_TYPE_COUNT = 8'h00;
	localparam logic [7:0] ADDR_CH1_TYPE = 8'h04;
	localparam logic [7:0] ADDR_CH2_TYPE = 8'h08;
	localparam logic [7:0] ADDR_CH3_TYPE = 8'h0c;
	localparam logic [7:0] ADDR_CH4_TYPE = 8'h10;
	localparam logic [7:0] ADDR_OUT_ASSIGN_COUNT = 8'h14;
	localparam logic [7:0] ADDR_OUT_ASSIGN_ENTRY1 = 8'h18;
	localparam logic [7:0] ADDR_IN_ASSIGN_COUNT = 8'h1c;
	localparam logic [7:0] ADDR_IN_ASSIGN_ENTRY1 = 8'h20;
	localparam logic [7:0] ADDR_IN_ASSIGN_ENTRY2 = 8'h24;
	localparam logic [7:0] ADDR_OUT_SYNC_PARAM_COUNT = 8'h28;
	localparam logic [7:0] ADDR_OUT_SYNC_SELECTION = 8'h2c;
	localparam logic [7:0] ADDR_OUT_CYCLE_PERIOD = 8'h30;
	localparam logic [7:0] ADDR_OUT_SHIFT = 8'h34;
	localparam logic [7:0] ADDR_OUT_SUPPORTED_MODES = 8'h38;
	localparam logic [7:0] ADDR_OUT_MIN_PERIOD = 8'h3c;
	localparam logic [7:0] ADDR_OUT_CALC_COPY = 8'h40;
	localparam logic [7:0] ADDR_OUT_MIN_DELAY = 8'h44;
	localparam logic [7:0] ADDR_OUT_MEASURE_COMMAND = 8'h48;
	localparam logic [7:0] ADDR_OUT_MAX_DELAY = 8'h4c;
	localparam logic [7:0] ADDR_MISSED_EVENT_TALLY = 8'h50;
	localparam logic [7:0] ADDR_OVERRUN_CYCLE_TALLY = 8'h54;
	localparam logic [7:0] ADDR_SHORT_GAP_TALLY = 8'h58;
	localparam logic [7:0] ADDR_LATE_OUTPUT_FLAG = 8'h5c;
	localparam logic [7:0] ADDR_IN_SYNC_SELECTION = 8'h60;
	localparam logic [7:0] ADDR_IN_SHIFT = 8'h64;
	localparam logic [7:0] ADDR_IN_CALC_COPY = 8'h68;
	localparam logic [7:0] ADDR_IN_MAX_DELAY = 8'h6c;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h70;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h74;

	// ----------------------------------------
	// reset and constant values
	// ----------------------------------------
	localparam logic [7:0] TYPE_COUNT_RST = 8'h04;
	localparam logic [7:0] CH1_TYPE_RST = 8'h01;
	localparam logic [7:0] CH2_TYPE_RST = 8'h02;
	localparam logic [7:0] CH3_TYPE_RST = 8'h03;
	localparam logic [7:0] CH4_TYPE_RST = 8'h04;
	localparam logic [7:0] OUT_ASSIGN_COUNT_RST = 8'h01;
	localparam logic [15:0] OUT_ASSIGN_ENTRY1_RST = 16'h1600;
	localparam logic [7:0] IN_ASSIGN_COUNT_RST = 8'h02;
	localparam logic [15:0] IN_ASSIGN_ENTRY1_RST = 16'h1a00;
	localparam logic [15:0] IN_ASSIGN_ENTRY2_RST = 16'h1a01;
	localparam logic [7:0] SYNC_PARAM_COUNT_RST = 8'h20;
	localparam logic [31:0] CYCLE_PERIOD_RST = 32'h000f4240;
	localparam logic [15:0] SUPPORTED_MODES = 16'hc007;
	localparam int SUP_FREE_RUN_BIT = 0;
	localparam int SUP_SM_EVENT_BIT = 1;
	localparam int SUP_DYNAMIC_BIT = 14;
	localparam logic [31:0] MIN_PERIOD_RST = 32'h0000e6dc;
	localparam logic [31:0] MIN_DELAY_RST = 32'h00000000;
	localparam logic [31:0] TIME_CLEAR = 32'h00000000;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [15:0] CNT_ONE = 16'h0001;

	// ----------------------------------------
	// mode and command codes
	// ----------------------------------------
	localparam logic [15:0] OUT_MODE_FREE_RUN = 16'h0000;
	localparam logic [15:0] OUT_MODE_SM_EVENT = 16'h0001;
	localparam logic [15:0] IN_MODE_FREE_RUN = 16'h0000;
	localparam logic [15:0] IN_MODE_SM_IN = 16'h0001;
	localparam logic [15:0] IN_MODE_SYNC0 = 16'h0002;
	localparam logic [15:0] IN_MODE_SYNC1 = 16'h0003;
	localparam logic [15:0] IN_MODE_SM_OUT = 16'h0022;
	localparam logic [15:0] CMD_STOP = 16'h0000;
	localparam logic [15:0] CMD_START = 16'h0001;

	// ----------------------------------------
	// measured value slots, counter and interrupt bit positions
	// ----------------------------------------
	localparam int MEAS_N = 7;
	localparam int MEAS_OUT_SHIFT = 0;
	localparam int MEAS_OUT_CALC = 1;
	localparam int MEAS_OUT_DELAY = 2;
	localparam int MEAS_IN_SHIFT = 3;
	localparam int MEAS_IN_CALC = 4;
	localparam int MEAS_IN_DELAY = 5;
	localparam int MEAS_MIN_CYCLE = 6;
	localparam int CNT_N = 3;
	localparam int IRQ_MISSED = 0;
	localparam int IRQ_OVERRUN = 1;
	localparam int IRQ_SHORT_GAP = 2;
	localparam int IRQ_LATE = 3;
	localparam int IRQ_N = 4;

endpackage : smcp_pkg

//--- design/smcp_regs.sv
// register bank for sync manager roles, assignment and output cycle parameters
module smcp_regs (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// avalon-mm slave
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	// device state and events
	input wire logic opState,
	input wire logic dcMode,
	input wire logic smEventMissed,
	input wire logic cycleExceeded,
	input wire logic shortGap,
	input wire logic lateOutput,
	input wire logic cycleDone,
	// measured timing samples
	input wire logic measValid,
	input wire logic [31:0] measOutShift,
	input wire logic [31:0] measOutCalc,
	input wire logic [31:0] measOutDelay,
	input wire logic [31:0] measInShift,
	input wire logic [31:0] measInCalc,
	input wire logic [31:0] measInDelay,
	input wire logic [31:0] measCycle,
	// configuration to the device
	output logic [15:0] outSyncMode,
	output logic [15:0] inSyncMode,
	output logic [31:0] cyclePeriod,
	output logic measureRun,
	// interrupt
	output logic irq
);

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [7:0] outCnt;
		logic [15:0] outEnt;
		logic [7:0] inCnt;
		logic [15:0] inEnt1;
		logic [15:0] inEnt2;
		logic [15:0] outMode;
		logic [15:0] inMode;
		logic [31:0] period;
		logic [15:0] cmd;
		logic [smcp_pkg::MEAS_N-1:0][31:0] meas;
		logic [smcp_pkg::CNT_N-1:0][15:0] cnt;
		logic late;
		logic [smcp_pkg::IRQ_N-1:0] status;
		logic [smcp_pkg::IRQ_N-1:0] mask;
	} smcp_state_t;

	localparam smcp_state_t ST_RST = '{
		ack: 1'b0,
		rdata: 32'h00000000,
		outCnt: smcp_pkg::OUT_ASSIGN_COUNT_RST,
		outEnt: smcp_pkg::OUT_ASSIGN_ENTRY1_RST,
		inCnt: smcp_pkg::IN_ASSIGN_COUNT_RST,
		inEnt1: smcp_pkg::IN_ASSIGN_ENTRY1_RST,
		inEnt2: smcp_pkg::IN_ASSIGN_ENTRY2_RST,
		outMode: smcp_pkg::OUT_MODE_SM_EVENT,
		inMode: smcp_pkg::IN_MODE_SM_OUT,
		period: smcp_pkg::CYCLE_PERIOD_RST,
		cmd: smcp_pkg::CMD_STOP,
		meas: {smcp_pkg::MIN_PERIOD_RST, {(smcp_pkg::MEAS_N-1){smcp_pkg::TIME_CLEAR}}},
		cnt: {smcp_pkg::CNT_N{smcp_pkg::CNT_RST}},
		late: 1'b0,
		status: 4'h0,
		mask: 4'h0
	};

	smcp_state_t st;
	smcp_state_t next_st;
	logic [31:0] merged;
	logic [31:0] sample [smcp_pkg::MEAS_N];
	logic [smcp_pkg::CNT_N-1:0] cntHit;
	logic [smcp_pkg::IRQ_N-1:0] evt;
	logic [smcp_pkg::IRQ_N-1:0] clr;
	logic wrAcc;
	logic startMeas;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic logic [31:0] readMux(input smcp_state_t s, input logic [7:0] a);
		logic [31:0] d;
		d = 32'h00000000;
		case (a)
			smcp_pkg::ADDR_TYPE_COUNT: d = {24'h000000, smcp_pkg::TYPE_COUNT_RST};
			smcp_pkg::ADDR_CH1_TYPE: d = {24'h000000, smcp_pkg::CH1_TYPE_RST};
			smcp_pkg::ADDR_CH2_TYPE: d = {24'h000000, smcp_pkg::CH2_TYPE_RST};
			smcp_pkg::ADDR_CH3_TYPE: d = {24'h000000, smcp_pkg::CH3_TYPE_RST};
			smcp_pkg::ADDR_CH4_TYPE: d = {24'h000000, smcp_pkg::CH4_TYPE_RST};
			smcp_pkg::ADDR_OUT_ASSIGN_COUNT: d = {24'h000000, s.outCnt};
			smcp_pkg::ADDR_OUT_ASSIGN_ENTRY1: d = {16'h0000, s.outEnt};
			smcp_pkg::ADDR_IN_ASSIGN_COUNT: d = {24'h000000, s.inCnt};
			smcp_pkg::ADDR_IN_ASSIGN_ENTRY1: d = {16'h0000, s.inEnt1};
			smcp_pkg::ADDR_IN_ASSIGN_ENTRY2: d = {16'h0000, s.inEnt2};
			smcp_pkg::ADDR_OUT_SYNC_PARAM_COUNT: d = {24'h000000, smcp_pkg::SYNC_PARAM_COUNT_RST};
			smcp_pkg::ADDR_OUT_SYNC_SELECTION: d = {16'h0000, s.outMode};
			smcp_pkg::ADDR_OUT_CYCLE_PERIOD: d = s.period;
			smcp_pkg::ADDR_OUT_SHIFT: d = s.meas[smcp_pkg::MEAS_OUT_SHIFT];
			smcp_pkg::ADDR_OUT_SUPPORTED_MODES: d = {16'h0000, smcp_pkg::SUPPORTED_MODES};
			smcp_pkg::ADDR_OUT_MIN_PERIOD: d = s.meas[smcp_pkg::MEAS_MIN_CYCLE];
			smcp_pkg::ADDR_OUT_CALC_COPY: d = s.meas[smcp_pkg::MEAS_OUT_CALC];
			smcp_pkg::ADDR_OUT_MIN_DELAY: d = smcp_pkg::MIN_DELAY_RST;
			smcp_pkg::ADDR_OUT_MEASURE_COMMAND: d = {16'h0000, s.cmd};
			smcp_pkg::ADDR_OUT_MAX_DELAY: d = s.meas[smcp_pkg::MEAS_OUT_DELAY];
			smcp_pkg::ADDR_MISSED_EVENT_TALLY: d = {16'h0000, s.cnt[smcp_pkg::IRQ_MISSED]};
			smcp_pkg::ADDR_OVERRUN_CYCLE_TALLY: d = {16'h0000, s.cnt[smcp_pkg::IRQ_OVERRUN]};
			smcp_pkg::ADDR_SHORT_GAP_TALLY: d = {16'h0000, s.cnt[smcp_pkg::IRQ_SHORT_GAP]};
			smcp_pkg::ADDR_LATE_OUTPUT_FLAG: d = {31'h00000000, s.late};
			smcp_pkg::ADDR_IN_SYNC_SELECTION: d = {16'h0000, s.inMode};
			smcp_pkg::ADDR_IN_SHIFT: d = s.meas[smcp_pkg::MEAS_IN_SHIFT];
			smcp_pkg::ADDR_IN_CALC_COPY: d = s.meas[smcp_pkg::MEAS_IN_CALC];
			smcp_pkg::ADDR_IN_MAX_DELAY: d = s.meas[smcp_pkg::MEAS_IN_DELAY];
			smcp_pkg::ADDR_IRQ_STATUS: d = {28'h0000000, s.status};
			smcp_pkg::ADDR_IRQ_MASK: d = {28'h0000000, s.mask};
			default: d = 32'h00000000;
		endcase
		return d;
	endfunction : readMux

	function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction : mergeBytes

	// ----------------------------------------
	// next state
	// ----------------------------------------
	// every access answers on its second cycle; read data is fetched in the first
	assign waitrequest = (read | write) & ~st.ack;
	assign wrAcc = write & st.ack;
	assign merged = mergeBytes(readMux(st, address), writedata, byteenable);
	assign startMeas = wrAcc && address == smcp_pkg::ADDR_OUT_MEASURE_COMMAND
		&& merged[15:0] == smcp_pkg::CMD_START && st.cmd != smcp_pkg::CMD_START;
	assign cntHit[smcp_pkg::IRQ_MISSED] = smEventMissed & opState & dcMode;
	assign cntHit[smcp_pkg::IRQ_OVERRUN] = cycleExceeded & opState;
	assign cntHit[smcp_pkg::IRQ_SHORT_GAP] = shortGap & dcMode;
	assign evt = {lateOutput & dcMode, cntHit};
	assign clr = (wrAcc && address == smcp_pkg::ADDR_IRQ_STATUS && byteenable[0])
		? writedata[smcp_pkg::IRQ_N-1:0] : 4'h0;

	always_comb begin
		sample[smcp_pkg::MEAS_OUT_SHIFT] = measOutShift;
		sample[smcp_pkg::MEAS_OUT_CALC] = measOutCalc;
		sample[smcp_pkg::MEAS_OUT_DELAY] = measOutDelay;
		sample[smcp_pkg::MEAS_IN_SHIFT] = measInShift;
		sample[smcp_pkg::MEAS_IN_CALC] = measInCalc;
		sample[smcp_pkg::MEAS_IN_DELAY] = measInDelay;
		sample[smcp_pkg::MEAS_MIN_CYCLE] = measCycle;
		next_st = st;
		next_st.ack = (read | write) & ~st.ack;
		if ((read | write) && !st.ack) begin
			next_st.rdata = readMux(st, address);
		end
		if (wrAcc) begin
			case (address)
				smcp_pkg::ADDR_OUT_ASSIGN_COUNT: next_st.outCnt = merged[7:0];
				smcp_pkg::ADDR_OUT_ASSIGN_ENTRY1: next_st.outEnt = merged[15:0];
				smcp_pkg::ADDR_IN_ASSIGN_COUNT: next_st.inCnt = merged[7:0];
				smcp_pkg::ADDR_IN_ASSIGN_ENTRY1: next_st.inEnt1 = merged[15:0];
				smcp_pkg::ADDR_IN_ASSIGN_ENTRY2: next_st.inEnt2 = merged[15:0];
				smcp_pkg::ADDR_OUT_SYNC_SELECTION: next_st.outMode = merged[15:0];
				smcp_pkg::ADDR_IN_SYNC_SELECTION: next_st.inMode = merged[15:0];
				smcp_pkg::ADDR_OUT_CYCLE_PERIOD: next_st.period = merged;
				smcp_pkg::ADDR_OUT_MEASURE_COMMAND: next_st.cmd = merged[15:0];
				smcp_pkg::ADDR_IRQ_MASK: next_st.mask = merged[smcp_pkg::IRQ_N-1:0];
				default: next_st.rdata = st.rdata;
			endcase
		end
		// samples arriving while stopped are dropped, not held for later
		for (int i = 0; i < smcp_pkg::MEAS_N; i++) begin
			if (st.cmd == smcp_pkg::CMD_START && measValid && sample[i] > st.meas[i]) begin
				next_st.meas[i] = sample[i];
			end
			if (startMeas) begin
				next_st.meas[i] = (i == smcp_pkg::MEAS_MIN_CYCLE)
					? smcp_pkg::MIN_PERIOD_RST : smcp_pkg::TIME_CLEAR;
			end
		end
		// counters stop at all ones so a long fault history is not lost to a wrap
		for (int i = 0; i < smcp_pkg::CNT_N; i++) begin
			if (cntHit[i] && st.cnt[i] != smcp_pkg::CNT_MAX) begin
				next_st.cnt[i] = st.cnt[i] + smcp_pkg::CNT_ONE;
			end
		end
		if (cycleDone) begin
			next_st.late = 1'b0;
		end
		if (lateOutput && dcMode) begin
			next_st.late = 1'b1;
		end
		// a fresh event beats a clear in the same cycle
		next_st.status = (st.status & ~clr) | evt;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= ST_RST;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign readdata = st.rdata;
	assign outSyncMode = st.outMode;
	assign inSyncMode = st.inMode;
	assign cyclePeriod = st.period;
	assign measureRun = st.cmd == smcp_pkg::CMD_START;
	assign irq = |(st.status & st.mask);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_bus_answer: assert property (@(posedge clk) disable iff (!arst_n)
		(read || write) && waitrequest |=> !waitrequest)
		else $error("access not answered in one cycle");
	a_type_count: assert property (@(posedge clk) disable iff (!arst_n)
		read && !waitrequest && $past(address) == smcp_pkg::ADDR_TYPE_COUNT
		&& address == smcp_pkg::ADDR_TYPE_COUNT |-> readdata == 32'h00000004)
		else $error("channel count wrong");
	a_modes_mask: assert property (@(posedge clk) disable iff (!arst_n)
		read && !waitrequest && $past(address) == smcp_pkg::ADDR_OUT_SUPPORTED_MODES
		&& address == smcp_pkg::ADDR_OUT_SUPPORTED_MODES |-> readdata == 32'h0000c007)
		else $error("supported modes wrong");
	a_min_floor: assert property (@(posedge clk) disable iff (!arst_n)
		st.meas[smcp_pkg::MEAS_MIN_CYCLE] >= smcp_pkg::MIN_PERIOD_RST)
		else $error("minimum cycle below floor");
	a_start_clears: assert property (@(posedge clk) disable iff (!arst_n)
		startMeas |=> st.meas[smcp_pkg::MEAS_OUT_SHIFT] == 32'h00000000
		&& st.meas[smcp_pkg::MEAS_IN_DELAY] == 32'h00000000 && measureRun)
		else $error("measurement start did not clear");
	a_meas_max: assert property (@(posedge clk) disable iff (!arst_n)
		measureRun && measValid && !startMeas
		&& measOutDelay > st.meas[smcp_pkg::MEAS_OUT_DELAY]
		|=> st.meas[smcp_pkg::MEAS_OUT_DELAY] == $past(measOutDelay))
		else $error("maximum not captured");
	a_meas_stopped: assert property (@(posedge clk) disable iff (!arst_n)
		!measureRun && !startMeas |=> $stable(st.meas))
		else $error("timing changed while stopped");
	a_missed_count: assert property (@(posedge clk) disable iff (!arst_n)
		smEventMissed && opState && dcMode && st.cnt[smcp_pkg::IRQ_MISSED] != 16'hffff
		|=> st.cnt[smcp_pkg::IRQ_MISSED] == $past(st.cnt[smcp_pkg::IRQ_MISSED]) + 16'h0001)
		else $error("missed event not counted");
	a_missed_gate: assert property (@(posedge clk) disable iff (!arst_n)
		!(opState && dcMode) |=> $stable(st.cnt[smcp_pkg::IRQ_MISSED]))
		else $error("missed counter moved outside mode");
	a_overrun_count: assert property (@(posedge clk) disable iff (!arst_n)
		cycleExceeded && opState && st.cnt[smcp_pkg::IRQ_OVERRUN] != 16'hffff
		|=> st.cnt[smcp_pkg::IRQ_OVERRUN] == $past(st.cnt[smcp_pkg::IRQ_OVERRUN]) + 16'h0001)
		else $error("overrun not counted");
	a_overrun_gate: assert property (@(posedge clk) disable iff (!arst_n)
		!opState |=> $stable(st.cnt[smcp_pkg::IRQ_OVERRUN]))
		else $error("overrun counted outside operational state");
	a_gap_count: assert property (@(posedge clk) disable iff (!arst_n)
		shortGap && dcMode && st.cnt[smcp_pkg::IRQ_SHORT_GAP] != 16'hffff
		|=> st.cnt[smcp_pkg::IRQ_SHORT_GAP] == $past(st.cnt[smcp_pkg::IRQ_SHORT_GAP]) + 16'h0001)
		else $error("short gap not counted");
	a_gap_gate: assert property (@(posedge clk) disable iff (!arst_n)
		!dcMode |=> $stable(st.cnt[smcp_pkg::IRQ_SHORT_GAP]))
		else $error("short gap counted outside clock mode");
	a_cnt_saturate: assert property (@(posedge clk) disable iff (!arst_n)
		st.cnt[smcp_pkg::IRQ_OVERRUN] == 16'hffff |=> st.cnt[smcp_pkg::IRQ_OVERRUN] == 16'hffff)
		else $error("counter wrapped");
	a_late_set: assert property (@(posedge clk) disable iff (!arst_n)
		lateOutput && dcMode |=> st.late ##0 st.status[smcp_pkg::IRQ_LATE])
		else $error("late output not flagged");
	a_late_clear: assert property (@(posedge clk) disable iff (!arst_n)
		cycleDone && !(lateOutput && dcMode) |=> !st.late)
		else $error("late flag not cleared by cycle end");
	a_out_mode: assert property (@(posedge clk) disable iff (!arst_n)
		wrAcc && address == smcp_pkg::ADDR_OUT_SYNC_SELECTION && byteenable == 4'hf
		|=> outSyncMode == $past(writedata[15:0]))
		else $error("output sync mode write lost");
	a_status_sticky: assert property (@(posedge clk) disable iff (!arst_n)
		evt != 4'h0 |=> (st.status & $past(evt)) == $past(evt))
		else $error("event did not set its status bit");
	a_irq_level: assert property (@(posedge clk) disable iff (!arst_n)
		cntHit[smcp_pkg::IRQ_MISSED] && st.mask[smcp_pkg::IRQ_MISSED]
		&& !(wrAcc && address == smcp_pkg::ADDR_IRQ_MASK) |=> irq)
		else $error("unmasked event raised no interrupt");

endmodule : smcp_regs

//--- verification/smcp_master_model.sv
// behavioural far side: device state, cycle events and timing samples
module smcp_master_model (
	// clock
	input wire logic clk,
	// device state and cycle events: missed, overrun, short gap, late, cycle done
	output logic opState,
	output logic dcMode,
	output logic [4:0] evt,
	// timing samples, slot k carries base plus k
	output logic measValid,
	output logic [31:0] measBase
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		opState = 1'b0;
		dcMode = 1'b0;
		evt = 5'h00;
		measValid = 1'b0;
		measBase = 32'h00000000;
	end

	task automatic setState(input logic op, input logic dc);
		@(posedge clk);
		opState <= op;
		dcMode <= dc;
	endtask : setState

	// an event line stays high n cycles, one event per edge
	task automatic pulse(input int idx, input int n);
		@(posedge clk);
		evt[idx] <= 1'b1;
		repeat (n) @(posedge clk);
		evt[idx] <= 1'b0;
	endtask : pulse

	// samples turn to garbage once valid drops, so stale reuse would show
	task automatic sample(input logic [31:0] v);
		@(posedge clk);
		measBase <= v;
		measValid <= 1'b1;
		@(posedge clk);
		measBase <= ~v;
		measValid <= 1'b0;
	endtask : sample
endmodule : smcp_master_model

//--- verification/sync_manager_cycle_params_bench.sv
// self-checking bench for the sync manager cycle parameter register bank
module sync_manager_cycle_params_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// tables
	// ----------------------------------------
	localparam int LIMIT = 80000;
	localparam logic [39:0] RST_TAB [31] = '{
		40'h00_00000004, 40'h04_00000001, 40'h08_00000002, 40'h0c_00000003, 40'h10_00000004,
		40'h14_00000001, 40'h18_00001600, 40'h1c_00000002, 40'h20_00001a00, 40'h24_00001a01,
		40'h28_00000020, 40'h2c_00000001, 40'h30_000f4240, 40'h34_00000000, 40'h38_0000c007,
		40'h3c_0000e6dc, 40'h40_00000000, 40'h44_00000000, 40'h48_00000000, 40'h4c_00000000,
		40'h50_00000000, 40'h54_00000000, 40'h58_00000000, 40'h5c_00000000, 40'h60_00000022,
		40'h64_00000000, 40'h68_00000000, 40'h6c_00000000, 40'h70_00000000, 40'h74_00000000,
		40'h7c_00000000};
	localparam logic [7:0] RO_ADDR [11] = '{8'h00, 8'h04, 8'h10, 8'h28, 8'h34, 8'h38, 8'h3c,
		8'h44, 8'h50, 8'h5c, 8'h7c};
	localparam logic [7:0] MEAS_ADDR [7] = '{8'h34, 8'h40, 8'h4c, 8'h64, 8'h68, 8'h6c, 8'h3c};
	localparam logic [15:0] IN_MODES [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0022};
	localparam logic [1:0] ST [3] = '{2'b01, 2'b10, 2'b11};
	localparam logic [63:0] EXP_CNT [3] = '{64'h0000_0000_0001_0001, 64'h0000_0001_0001_0000,
		64'h0001_0002_0002_0001};

	logic clk;
	logic arst_n;
	logic read;
	logic write;
	logic waitrequest;
	logic opState;
	logic dcMode;
	logic measValid;
	logic measureRun;
	logic irq;
	logic [7:0] address;
	logic [3:0] byteenable;
	logic [4:0] evt;
	logic [15:0] outSyncMode;
	logic [15:0] inSyncMode;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic [31:0] measBase;
	logic [31:0] cyclePeriod;
	int badCount;
	int checks;
	int cycles;

	smcp_regs smcp_regs_i (.clk(clk), .arst_n(arst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .opState(opState), .dcMode(dcMode), .smEventMissed(evt[0]),
		.cycleExceeded(evt[1]), .shortGap(evt[2]), .lateOutput(evt[3]), .cycleDone(evt[4]),
		.measValid(measValid), .measOutShift(measBase), .measOutCalc(measBase + 32'h1),
		.measOutDelay(measBase + 32'h2), .measInShift(measBase + 32'h3),
		.measInCalc(measBase + 32'h4), .measInDelay(measBase + 32'h5),
		.measCycle(measBase + 32'h6), .outSyncMode(outSyncMode), .inSyncMode(inSyncMode),
		.cyclePeriod(cyclePeriod), .measureRun(measureRun), .irq(irq));

	smcp_master_model smcp_master_model_i (.clk(clk), .opState(opState), .dcMode(dcMode),
		.evt(evt), .measValid(measValid), .measBase(measBase));

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic print_verdict;
		if (badCount == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			badCount++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic busWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk);
		address <= a;
		writedata <= d;
		byteenable <= be;
		write <= 1'b1;
		do @(posedge clk); while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask : busWrite

	task automatic expectReg(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		@(posedge clk);
		address <= a;
		read <= 1'b1;
		do @(posedge clk); while (waitrequest !== 1'b0);
		d = readdata;
		read <= 1'b0;
		check(d, exp);
	endtask : expectReg

	// register outputs land on the answering edge itself; the second edge is margin
	task automatic settle;
		repeat (2) @(posedge clk);
	endtask : settle

	// ----------------------------------------
	// clock, timeout and sequence
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			badCount++;
			print_verdict();
		end
	end

	initial begin
		arst_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 8'h00;
		writedata = 32'h00000000;
		byteenable = 4'h0;
		badCount = 0;
		checks = 0;
		cycles = 0;
		repeat (12) @(posedge clk);
		check(outSyncMode, 16'h0001);
		check(inSyncMode, 16'h0022);
		check(cyclePeriod, 32'h000f4240);
		check(measureRun, 1'b0);
		arst_n <= 1'b1;
		foreach (RST_TAB[i]) expectReg(RST_TAB[i][39:32], RST_TAB[i][31:0]);
		// read-only words and the hole at 0x7c must shrug off writes
		foreach (RO_ADDR[i]) busWrite(RO_ADDR[i], 32'hffffffff, 4'hf);
		foreach (RST_TAB[i]) expectReg(RST_TAB[i][39:32], RST_TAB[i][31:0]);
		busWrite(8'h2c, 32'h00000000, 4'hf);
		busWrite(8'h30, 32'h0007a120, 4'hf);
		busWrite(8'h30, 32'hffffff55, 4'h1);
		busWrite(8'h18, 32'h00001a02, 4'hf);
		busWrite(8'h24, 32'h00001a05, 4'hf);
		busWrite(8'h14, 32'h00000000, 4'hf);
		busWrite(8'h1c, 32'h00000001, 4'hf);
		busWrite(8'h20, 32'h00001a03, 4'hf);
		expectReg(8'h14, 32'h00000000);
		expectReg(8'h1c, 32'h00000001);
		expectReg(8'h20, 32'h00001a03);
		settle();
		check(outSyncMode, 16'h0000);
		check(cyclePeriod, 32'h0007a155);
		expectReg(8'h18, 32'h00001a02);
		expectReg(8'h24, 32'h00001a05);
		foreach (IN_MODES[i]) begin
			busWrite(8'h60, {16'h0000, IN_MODES[i]}, 4'hf);
			settle();
			check(inSyncMode, IN_MODES[i]);
		end
		busWrite(8'h48, 32'h00000001, 4'hf);
		settle();
		check(measureRun, 1'b1);
		smcp_master_model_i.sample(32'h00010000);
		smcp_master_model_i.sample(32'h00000100);
		foreach (MEAS_ADDR[i]) expectReg(MEAS_ADDR[i], 32'h00010000 + i);
		busWrite(8'h48, 32'h00000000, 4'hf);
		settle();
		check(measureRun, 1'b0);
		smcp_master_model_i.sample(32'h00020000);
		foreach (MEAS_ADDR[i]) expectReg(MEAS_ADDR[i], 32'h00010000 + i);
		busWrite(8'h48, 32'h00000001, 4'hf);
		foreach (MEAS_ADDR[i]) expectReg(MEAS_ADDR[i], (i == 6) ? 32'h0000e6dc : 32'h0);
		foreach (ST[p]) begin
			smcp_master_model_i.setState(ST[p][1], ST[p][0]);
			for (int k = 0; k < 4; k++) smcp_master_model_i.pulse(k, 1);
			expectReg(8'h50, EXP_CNT[p][63:48]);
			expectReg(8'h54, EXP_CNT[p][47:32]);
			expectReg(8'h58, EXP_CNT[p][31:16]);
			expectReg(8'h5c, EXP_CNT[p][15:0]);
			smcp_master_model_i.pulse(4, 1);
			expectReg(8'h5c, 32'h00000000);
		end
		// every event kind has fired, all status bits sticky but masked off
		settle();
		check(irq, 1'b0);
		expectReg(8'h70, 32'h0000000f);
		busWrite(8'h74, 32'h00000004, 4'hf);
		settle();
		check(irq, 1'b1);
		busWrite(8'h70, 32'h00000004, 4'hf);
		settle();
		check(irq, 1'b0);
		expectReg(8'h70, 32'h0000000b);
		busWrite(8'h70, 32'h0000000b, 4'hf);
		expectReg(8'h70, 32'h00000000);
		// long overrun burst, costs most of the run time
		smcp_master_model_i.pulse(1, 65540);
		expectReg(8'h54, 32'h0000ffff);
		print_verdict();
	end
endmodule : sync_manager_cycle_params_bench
